/* File: hw/wms_pkg.sv */
// package: timing constants and pin bundle for the reset supervisor
package wms_pkg;

	// reference clock
	localparam int unsigned CLK_PERIOD_NS      = 10;

	// reset hold period after the last source releases
	localparam int unsigned HOLD_PERIOD_NS     = 200_000_000;
	localparam int unsigned HOLD_CYCLES        = HOLD_PERIOD_NS / CLK_PERIOD_NS;

	// watchdog timeout period without a kick edge
	localparam int unsigned WD_TIMEOUT_NS      = 1_600_000_000;
	localparam int unsigned WD_CYCLES          = WD_TIMEOUT_NS / CLK_PERIOD_NS;

	// manual reset low pulses shorter than this are noise; a pulse just under
	// the limit can still span that many samples, so the filter wants one more
	localparam int unsigned MR_IGNORE_NS       = 100;
	localparam int unsigned MR_FILT_CYCLES     = (MR_IGNORE_NS - 1) / CLK_PERIOD_NS + 2;

	// shortest kick pulse that must be seen (longest time, round down, at least one)
	localparam int unsigned KICK_PULSE_NS      = 50;
	localparam int unsigned KICK_PULSE_CYCLES  = (KICK_PULSE_NS / CLK_PERIOD_NS) > 0 ?
	                                             (KICK_PULSE_NS / CLK_PERIOD_NS) : 1;

	// self-drive goes high for the last eighth of the timeout
	localparam int unsigned SELF_DRIVE_DEN     = 8;
	localparam int unsigned SELF_DRIVE_HIGH_NUM = 1;

	// reset values of the synchroniser stages: inactive levels
	localparam logic        MR_IDLE            = 1'h1;
	localparam logic        KICK_IDLE          = 1'h0;
	localparam logic        SUPPLY_IDLE        = 1'h0;

	// asynchronous pins, carried together through the synchroniser
	typedef struct packed {
		logic manual_reset_in_n;
		logic watchdog_kick_in;
		logic supply_low;
	} wms_pins_t;

	localparam wms_pins_t PINS_IDLE = '{manual_reset_in_n: MR_IDLE,
	                                    watchdog_kick_in:  KICK_IDLE,
	                                    supply_low:        SUPPLY_IDLE};

endpackage : wms_pkg

/* File: hw/wms_supervisor.sv */
// module: reset supervisor with manual reset, watchdog and supply trip

// Notes on behaviour
// - manual reset input low asserts both reset outputs.
// - reset stays while manual input low, then one hold period after release.
// - an open manual reset input reads high, so never resets.
// - switch bounce on the manual input is absorbed internally.
// - no kick edge for one timeout period expires the watchdog and resets.
// - any reset or kick edge clears the watchdog counter; short pulses count.
// - while reset is asserted the watchdog counter stays at zero.
// - watchdog counter starts counting on the cycle reset releases.
// - an undriven or tri-stated kick line effectively disables the watchdog.
// - device weakly drives kick line low first 7/8, high last 1/8.
// - undriven, the self-drive clears the counter about every 7/8 timeout.
// - each watchdog, manual release or supply recovery reset lasts the hold period.
// - active-high reset is always the inverse of active-low reset.
// - supply trip asserts reset and restarts the hold timer.
// - manual reset low pulses under 100 ns are ignored.
module wms_supervisor
	import wms_pkg::*;
#(
	parameter int unsigned HOLD_LEN  = HOLD_CYCLES,
	parameter int unsigned WD_LEN    = WD_CYCLES,
	parameter int unsigned MR_FILT   = MR_FILT_CYCLES
) (
	input  wire logic clock_i,
	input  wire logic reset_i,
	input  wire logic manual_reset_in_n_i,
	input  wire logic watchdog_kick_in_i,
	input  wire logic supply_low_i,
	output logic      watchdog_kick_in_o,
	output logic      watchdog_kick_in_oe_o,
	output logic      reset_n_o,
	output logic      reset_o
);

	localparam int unsigned HW       = $clog2(HOLD_LEN + 1);
	localparam int unsigned WW       = $clog2(WD_LEN + 1);
	localparam int unsigned FW       = $clog2(MR_FILT + 1);
	localparam int unsigned SELF_HI  = WD_LEN - (WD_LEN * SELF_DRIVE_HIGH_NUM) / SELF_DRIVE_DEN;

	localparam logic [HW-1:0] HOLD_LOAD  = HOLD_LEN[HW-1:0];
	localparam logic [WW-1:0] WD_LAST    = WW'(WD_LEN - 1);
	localparam logic [WW-1:0] SELF_START = SELF_HI[WW-1:0];
	localparam logic [FW-1:0] FILT_LAST  = FW'(MR_FILT - 1);

	wms_pins_t       pins_meta;
	wms_pins_t       pins_sync;
	logic            kick_prev;
	logic            kick_edge;
	logic            mr_filt;
	logic [FW-1:0]   filt_cnt;
	logic [HW-1:0]   hold_cnt;
	logic [WW-1:0]   wd_cnt;
	logic            wd_expire;
	logic            trig;
	logic            next_reset;

	// two-flop synchroniser; only pins_sync is read by logic
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			pins_meta <= PINS_IDLE;
			pins_sync <= PINS_IDLE;
		end else begin
			pins_meta <= '{manual_reset_in_n: manual_reset_in_n_i,
			               watchdog_kick_in:  watchdog_kick_in_i,
			               supply_low:        supply_low_i};
			pins_sync <= pins_meta;
		end
	end

	// edge detector on the synchronised kick line, any direction
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			kick_prev <= KICK_IDLE;
		end else begin
			kick_prev <= pins_sync.watchdog_kick_in;
		end
	end

	assign kick_edge = pins_sync.watchdog_kick_in ^ kick_prev;

	// glitch filter: level must hold MR_FILT cycles before it is believed;
	// bounce keeps resetting the count, so a switch gives one clean reset
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			mr_filt  <= MR_IDLE;
			filt_cnt <= '0;
		end else if (pins_sync.manual_reset_in_n == mr_filt) begin
			filt_cnt <= '0;
		end else if (filt_cnt == FILT_LAST) begin
			mr_filt  <= pins_sync.manual_reset_in_n;
			filt_cnt <= '0;
		end else begin
			filt_cnt <= filt_cnt + FW'(1);
		end
	end

	// any active source; hold timer extends it after release
	assign wd_expire  = (wd_cnt == WD_LAST);
	assign trig       = pins_sync.supply_low | ~mr_filt | wd_expire;
	assign next_reset = trig | (hold_cnt != '0);

	// hold timer: reloaded while any source is active, counts down after
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			hold_cnt <= HOLD_LOAD; // power-on gets a full hold too
		end else if (trig) begin
			hold_cnt <= HOLD_LOAD;
		end else if (hold_cnt != '0) begin
			hold_cnt <= hold_cnt - HW'(1);
		end
	end

	// both reset outputs from flops fed by one value, so never skewed
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			reset_n_o <= 1'h0;
			reset_o   <= 1'h1;
		end else begin
			reset_n_o <= ~next_reset;
			reset_o   <= next_reset;
		end
	end

	// watchdog counter: zero while reset out is low, counts from its release
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			wd_cnt <= '0;
		end else if (~reset_n_o | kick_edge) begin
			wd_cnt <= '0;
		end else if (wd_cnt != WD_LAST) begin
			wd_cnt <= wd_cnt + WW'(1);
		end
	end

	// weak self-drive of the kick line from the counter: an open line thus
	// sees a low-high-low pulse near 7/8 of the timeout and never expires;
	// a stronger external driver simply overrides it
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			watchdog_kick_in_o    <= 1'h0;
			watchdog_kick_in_oe_o <= 1'h0;
		end else begin
			watchdog_kick_in_o    <= (wd_cnt >= SELF_START);
			watchdog_kick_in_oe_o <= 1'h1;
		end
	end

	// checks
	default clocking chk_clk @(posedge clock_i); endclocking
	default disable iff (reset_i);

	chk_mr_low_asserts: assert property (
		!mr_filt |=> !reset_n_o && reset_o)
		else $error("manual reset low did not assert reset");

	chk_hold_after_release: assert property (
		$fell(trig) |-> hold_cnt == HOLD_LOAD ##1 (!reset_n_o && hold_cnt == HOLD_LOAD - HW'(1)))
		else $error("hold period not started on release");

	chk_hold_end_release: assert property (
		(!trig && hold_cnt == HW'(1)) ##1 !trig |=> reset_n_o)
		else $error("reset not released at end of hold");

	chk_outputs_inverse: assert property (
		reset_o == !reset_n_o)
		else $error("reset outputs not complementary");

	chk_supply_restarts: assert property (
		pins_sync.supply_low |=> !reset_n_o && hold_cnt == HOLD_LOAD)
		else $error("supply trip did not restart hold");

	chk_filter_length: assert property (
		(mr_filt != $past(mr_filt)) |-> $past(filt_cnt) == FILT_LAST)
		else $error("manual filter switched early");

	chk_short_low_ignored: assert property (
		(mr_filt && pins_sync.manual_reset_in_n) ##1 !pins_sync.manual_reset_in_n
		##1 pins_sync.manual_reset_in_n |=> mr_filt)
		else $error("single-cycle manual glitch passed filter");

	chk_wd_held_zero: assert property (
		!reset_n_o |=> wd_cnt == '0)
		else $error("watchdog counted during reset");

	chk_wd_starts: assert property (
		$rose(reset_n_o) && !kick_edge |=> wd_cnt == WW'(1))
		else $error("watchdog did not start on release");

	chk_wd_expires: assert property (
		reset_n_o && wd_cnt == WD_LAST |=> !reset_n_o ##1 wd_cnt == '0)
		else $error("watchdog expiry did not reset");

	chk_kick_clears: assert property (
		kick_edge |=> wd_cnt == '0)
		else $error("kick edge did not clear counter");

	chk_self_high: assert property (
		wd_cnt == SELF_START |=> watchdog_kick_in_o && watchdog_kick_in_oe_o)
		else $error("self-drive not high in last eighth");

	chk_self_low: assert property (
		wd_cnt < SELF_START ##1 wd_cnt < SELF_START |-> !watchdog_kick_in_o)
		else $error("self-drive high too early");

	chk_any_source: assert property (
		trig |=> !reset_n_o && reset_o)
		else $error("active source did not assert reset");

	chk_hold_keeps_reset: assert property (
		!trig && hold_cnt != '0 |=> !reset_n_o)
		else $error("reset released while hold ran");

	cov_manual_release: cover property (!mr_filt ##1 mr_filt);
	cov_wd_expire:      cover property (reset_n_o && wd_expire);
	cov_supply_trip:    cover property ($rose(pins_sync.supply_low));
	cov_self_service:   cover property (watchdog_kick_in_o ##[1:4] kick_edge);

endmodule : wms_supervisor

/* File: verification/wms_host_model.sv */
// host side of the watchdog kick wire: strong driver or released line
module wms_host_model (
	input  wire logic clock_i,
	input  wire logic drive_en_i,
	input  wire logic drive_val_i,
	input  wire logic self_val_i,
	input  wire logic self_oe_i,
	output logic      wire_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic last = 1'h0;

	// remember the wire so a floating line never shows a stale level
	always_ff @(posedge clock_i) begin
		last <= wire_o;
	end

	// host driver beats the weak self-drive; released with no drive it flips
	assign wire_o = drive_en_i ? drive_val_i : (self_oe_i ? self_val_i : ~last);
endmodule : wms_host_model

/* File: verification/wms_supervisor_tb.sv */
// self-checking bench for the reset supervisor
module wms_supervisor_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import wms_pkg::*;
	localparam int unsigned HL = 20;
	localparam int unsigned WL = 64;
	localparam int unsigned MF = 10;
	logic clock_i = 1'h0;
	logic reset_i = 1'h1;
	logic mr_n    = 1'h1;
	logic supply  = 1'h0;
	logic host_en = 1'h0;
	logic host_v  = 1'h0;
	logic kick_w, kick_o, kick_oe, rst_n, rst, hi, lo;
	int   n_errors = 0;
	int   checks = 0;
	int   n;

	// short periods keep the run brief
	always #5 clock_i = ~clock_i;
	wms_supervisor #(.HOLD_LEN(HL), .WD_LEN(WL), .MR_FILT(MF)) i_dut (.clock_i(clock_i), .reset_i(reset_i),
		.manual_reset_in_n_i(mr_n), .watchdog_kick_in_i(kick_w), .supply_low_i(supply),
		.watchdog_kick_in_o(kick_o), .watchdog_kick_in_oe_o(kick_oe), .reset_n_o(rst_n), .reset_o(rst));
	wms_host_model i_host (.clock_i(clock_i), .drive_en_i(host_en), .drive_val_i(host_v),
		.self_val_i(kick_o), .self_oe_i(kick_oe), .wire_o(kick_w));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic idle(input int c);
		repeat (c) @(negedge clock_i);
	endtask : idle
	// bounded wait for the reset output to reach a level
	task automatic wait_rst(input logic v, input int lim, output int k);
		k = 0;
		while (rst_n !== v && k < lim) begin
			@(negedge clock_i);
			k++;
		end
	endtask : wait_rst
	task automatic done(input string name);
		check(rst ^ rst_n, 1);
		$display("test %s finished", name);
	endtask : done
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up

	task automatic t_manual;
		mr_n = 1'h0;
		wait_rst(0, MF + 8, n);
		check(rst_n, 0);
		idle(40);
		check(rst_n, 0);
		mr_n = 1'h1;
		wait_rst(1, HL + MF + 12, n);
		check(n >= HL + MF && n <= HL + MF + 6, 1);
		// one-cycle glitch first, then a five-cycle one: neither may reset
		mr_n = 1'h0;
		idle(1);
		mr_n = 1'h1;
		idle(2);
		mr_n = 1'h0;
		idle(5);
		mr_n = 1'h1;
		wait_rst(0, 30, n);
		check(rst_n, 1);
		// bouncing switch should still give one clean reset
		repeat (3) begin
			mr_n = 1'h0;
			idle(3);
			mr_n = 1'h1;
			idle(3);
		end
		mr_n = 1'h0;
		idle(30);
		check(rst_n, 0);
		mr_n = 1'h1;
		wait_rst(1, HL + MF + 12, n);
		check(n >= HL + MF, 1);
		done("manual");
	endtask : t_manual
	task automatic t_supply;
		supply = 1'h1;
		wait_rst(0, 6, n);
		check(n <= 4, 1);
		supply = 1'h0;
		idle(HL / 2);
		supply = 1'h1;
		idle(2);
		supply = 1'h0;
		wait_rst(1, 2 * HL, n);
		check(n >= HL, 1);
		done("supply");
	endtask : t_supply
	task automatic t_watchdog;
		host_en = 1'h1;
		host_v = 1'h0;
		wait_rst(0, WL + 10, n);
		check(n >= WL - 6 && n <= WL + 3, 1);
		check(kick_o, 1);
		wait_rst(1, HL + 6, n);
		check(n >= HL - 1, 1);
		wait_rst(0, WL + 10, n);
		check(n >= WL - 2 && n <= WL + 2, 1);
		wait_rst(1, HL + 6, n);
		// short kick pulses well inside the timeout keep it alive
		repeat (6) begin
			idle(40);
			check(kick_o, 0);
			host_v = 1'h1;
			idle(5);
			host_v = 1'h0;
		end
		check(rst_n, 1);
		// set once, then stuck with no later clear: the watchdog must bite
		idle(10);
		host_v = 1'h1;
		wait_rst(0, WL + 10, n);
		check(n >= WL && n <= WL + 4, 1);
		wait_rst(1, HL + 6, n);
		host_v = 1'h0;
		check(kick_oe, 1);
		host_en = 1'h0;
		hi = 1'h0;
		lo = 1'h0;
		repeat (300) begin
			@(negedge clock_i);
			hi = hi | (kick_o === 1'h1);
			lo = lo | (rst_n !== 1'h1);
		end
		check(hi, 1);
		check(lo, 0);
		done("watchdog");
	endtask : t_watchdog

	initial begin
		repeat (6) @(negedge clock_i);
		reset_i = 1'h0;
		check(rst_n, 0);
		wait_rst(1, 100, n);
		check(n >= HL && n <= HL + 3, 1);
		done("power_on");
		t_manual;
		t_supply;
		t_watchdog;
		wrap_up;
	end
	initial begin
		#200000;
		n_errors++;
		wrap_up;
	end
endmodule : wms_supervisor_tb
